/* File: otr_top.sv */
`timescale 1ns/1ps
`include "otr_regs.svh"
module otr_top
    import otr_pkg::*;
#(
    parameter int unsigned DELAY_UNIT_CYC = `OTR_DELAY_UNIT_CYC
) (
    // Clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST_B,
    // Command port from the bus transport
    input  wire logic        CMD_WR,
    input  wire logic        CMD_RD,
    input  wire logic [7:0]  CMD_CODE,
    input  wire logic [15:0] CMD_WDATA,
    output logic [15:0]      CMD_RDATA,
    output logic             CMD_RVALID,
    output logic             CMD_UNSUP,
    // Stored defaults
    input  wire logic [7:0]  NVM_RESP,
    input  wire logic [15:0] NVM_WARN,
    input  wire logic [15:0] NVM_FAULT,
    input  wire logic        NVM_RESTORE,
    // Telemetry and power stage
    input  wire logic [11:0] TEMP_DEG,
    input  wire logic        TEMP_VALID,
    input  wire logic        EN_PIN,
    input  wire logic        SOFTSTART_DONE,
    input  wire logic [23:0] TON_RISE_CYC,
    output logic             SWITCH_EN,
    output logic             LATCHED_OFF,
    // Status
    output logic             STATUS_TEMP,
    output logic             STATUS_OTF,
    output logic             STATUS_OTW,
    output logic             STATUS_CML,
    output logic             ALERT_B
);
    // Linear word to whole degrees, rounded to nearest
    function automatic logic signed [31:0] lin_to_deg(input logic [15:0] w);
        logic signed [4:0]  e;
        logic signed [31:0] m;
        logic [4:0]         sh;
        e  = w[`OTR_EXP_MSB:`OTR_EXP_LSB];
        m  = {{21{w[`OTR_MAN_MSB]}}, w[`OTR_MAN_MSB:0]};
        sh = 5'(-e);
        if (e >= 5'sd0) begin
            lin_to_deg = m <<< e; // see R19
        end else begin
            lin_to_deg = (m + (32'sd1 <<< (sh - 5'd1))) >>> sh;
        end
    endfunction : lin_to_deg

    function automatic logic valid_deg(input logic signed [31:0] d);
        valid_deg = (d == `OTR_LIMIT_OFF_DEG) ||
                    ((d >= `OTR_NVM_MIN_DEG) && (d <= `OTR_NVM_MAX_DEG));
    endfunction : valid_deg

    // Restored limits sit at whole degrees with zero exponent
    function automatic logic [15:0] nvm_round(input logic [15:0] w);
        logic signed [31:0] d;
        d = lin_to_deg(w);
        if (d != `OTR_LIMIT_OFF_DEG) begin
            if (d < `OTR_NVM_MIN_DEG) d = `OTR_NVM_MIN_DEG; // see R20
            if (d > `OTR_NVM_MAX_DEG) d = `OTR_NVM_MAX_DEG; // see R20
        end
        nvm_round = {5'h00, d[10:0]};
    endfunction : nvm_round

    logic               rst_s1_ff;
    logic               rst_n;
    otr_ctl_s           q;
    otr_ctl_s           nxt;
    logic signed [31:0] temp_s;
    logic signed [31:0] warn_deg;
    logic signed [31:0] fault_deg;
    logic signed [31:0] thr_deg;
    logic               warn_dis;
    logic               hot;
    logic               cool;
    logic               warm;
    logic               rel;
    logic               clr;
    logic               inv_evt;
    logic               go_shut;
    logic [1:0]         act;
    logic [2:0]         retry;
    logic [2:0]         dly;
    logic               tmr_load;
    otr_cnt_t           tmr_val;
    otr_cnt_t           delay_cyc;
    otr_cnt_t           restart_wait_period_cyc;
    logic               tmr_done;

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            rst_s1_ff <= 1'b0;
            rst_n     <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n     <= rst_s1_ff;
        end
    end

    assign act       = q.resp[`OTR_ACT_MSB:`OTR_ACT_LSB];
    assign retry     = q.resp[`OTR_RETRY_MSB:`OTR_RETRY_LSB];
    assign dly       = q.resp[`OTR_DLY_MSB:`OTR_DLY_LSB];
    assign temp_s    = {{20{TEMP_DEG[11]}}, TEMP_DEG};
    assign warn_deg  = lin_to_deg(q.warn);
    assign fault_deg = lin_to_deg(q.fault);
    assign warn_dis  = (warn_deg == `OTR_LIMIT_OFF_DEG); // see R21
    assign thr_deg   = (warn_dis || (warn_deg > fault_deg)) ?
                       (fault_deg - `OTR_HYST_DEG) : warn_deg; // see R15
    // Both limits judged on the same fresh sample
    assign hot  = TEMP_VALID && (fault_deg != `OTR_LIMIT_OFF_DEG) &&
                  (temp_s > fault_deg); // see R1, R23
    assign warm = TEMP_VALID && !warn_dis && (temp_s > warn_deg); // see R18, R23
    assign cool = TEMP_VALID && (temp_s < thr_deg); // see R14
    assign rel  = q.fault_act && cool;

    assign delay_cyc  = 32'(dly * DELAY_UNIT_CYC); // see R11, R12
    assign restart_wait_period_cyc = 32'(((dly == 3'h0) ? 3'h1 : dly) * TON_RISE_CYC); // see R11, R12

    always_comb begin
        nxt          = q;
        nxt.en_s1    = EN_PIN;
        nxt.en_s2    = q.en_s1;
        nxt.rd_valid = 1'b0;
        nxt.unsup    = 1'b0;
        clr          = 1'b0;
        inv_evt      = 1'b0;
        go_shut      = 1'b0;
        tmr_load     = 1'b0;
        tmr_val      = '0;
        if (!q.nvm_done || NVM_RESTORE) begin
            nxt.nvm_done = 1'b1;
            nxt.resp     = NVM_RESP;
            nxt.warn     = nvm_round(NVM_WARN); // see R20
            nxt.fault    = nvm_round(NVM_FAULT);
        end
        if (CMD_WR) begin
            case (CMD_CODE)
                `OTR_CMD_FAULT_ACTION: nxt.resp = CMD_WDATA[7:0];
                `OTR_CMD_WARN_THRESH: begin
                    if (valid_deg(lin_to_deg(CMD_WDATA))) nxt.warn = CMD_WDATA;
                    else inv_evt = 1'b1; // see R13
                end
                `OTR_CMD_FAULT_LIMIT: begin
                    if (valid_deg(lin_to_deg(CMD_WDATA))) nxt.fault = CMD_WDATA;
                    else inv_evt = 1'b1; // see R13
                end
                `OTR_CMD_CLEAR_FAULTS: clr = 1'b1;
                default: nxt.unsup = 1'b1;
            endcase
        end
        if (CMD_RD) begin
            nxt.rd_valid = 1'b1;
            case (CMD_CODE)
                `OTR_CMD_FAULT_ACTION: nxt.rdata = {8'h00, q.resp};
                `OTR_CMD_WARN_THRESH:  nxt.rdata = q.warn;
                `OTR_CMD_FAULT_LIMIT:  nxt.rdata = q.fault;
                `OTR_CMD_STATUS_BYTE:
                    nxt.rdata = 16'((16'(q.flag_otf | q.flag_otw) << `OTR_SB_TEMP_BIT) |
                                    (16'(q.flag_inv) << `OTR_SB_CML_BIT));
                `OTR_CMD_STATUS_TEMP:
                    nxt.rdata = 16'((16'(q.flag_otf) << `OTR_ST_OTF_BIT) |
                                    (16'(q.flag_otw) << `OTR_ST_OTW_BIT));
                default: begin
                    nxt.rdata = 16'h0000;
                    nxt.unsup = 1'b1;
                end
            endcase
        end
        // Set wins over a clear in the same cycle
        nxt.flag_otf = (q.flag_otf & ~clr) | hot; // see R2
        nxt.flag_otw = (q.flag_otw & ~clr) | warm; // see R18
        nxt.flag_inv = (q.flag_inv & ~clr) | inv_evt; // see R13
        // A clear may drop the condition so that no release ever follows
        if (clr) nxt.fault_act = 1'b0; // see R17
        if (cool) nxt.fault_act = 1'b0; // see R14
        if (hot) nxt.fault_act = 1'b1;

        case (q.st)
            ST_OFF: begin
                if (q.en_s2 && !q.fault_act) nxt.st = ST_START; // see R16
            end
            ST_START, ST_RUN: begin
                if (q.st == ST_START && SOFTSTART_DONE) begin
                    nxt.st  = ST_RUN;
                    nxt.cnt = 3'h0; // see R22
                end
                if (q.fault_act) begin
                    case (act)
                        ACT_DELAYED: begin
                            nxt.st   = ST_DELAY; // see R4
                            tmr_load = 1'b1;
                            tmr_val  = delay_cyc;
                        end
                        ACT_IMMEDIATE: go_shut = 1'b1; // see R5
                        ACT_COOL_DOWN: nxt.st = ST_COOL; // see R6
                        default: ; // see R3
                    endcase
                end
            end
            ST_DELAY: begin
                if (!q.fault_act) nxt.st = ST_RUN;
                else if (tmr_done) go_shut = 1'b1; // see R4
            end
            ST_WAIT: begin
                if (tmr_done) begin
                    // Attempts while still hot count but do not start
                    if (q.cnt != 3'h7) nxt.cnt = q.cnt + 3'h1; // see R9
                    if (q.fault_act) go_shut = 1'b1; // see R9
                    else nxt.st = ST_START;
                end
            end
            ST_COOL: begin
                if (rel) go_shut = 1'b1; // see R6
            end
            ST_LATCH: ;
            default: nxt.st = ST_OFF;
        endcase

        if (go_shut) begin
            if (retry == `OTR_RETRY_NONE) begin
                nxt.st = ST_LATCH; // see R7
            end else if (retry != `OTR_RETRY_FOREVER && nxt.cnt >= retry) begin
                nxt.st = ST_LATCH; // see R8
            end else begin
                nxt.st   = ST_WAIT; // see R8, R10
                tmr_load = 1'b1;
                tmr_val  = restart_wait_period_cyc;
            end
        end
        if (!q.en_s2) begin
            nxt.st  = ST_OFF;
            nxt.cnt = 3'h0; // see R22
        end
        nxt.sw_en = (nxt.st == ST_START) || (nxt.st == ST_RUN) || (nxt.st == ST_DELAY);
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            q       <= '0;
            q.resp  <= `OTR_RESP_RESET;
            q.warn  <= `OTR_WARN_RESET;
            q.fault <= `OTR_FAULT_RESET;
        end else begin
            q <= nxt;
        end
    end

    otr_timer u_timer (
        .clk   (CLK_SYS),
        .rst_n (rst_n),
        .load  (tmr_load),
        .value (tmr_val),
        .done  (tmr_done),
        .busy  ()
    );

    assign CMD_RDATA   = q.rdata;
    assign CMD_RVALID  = q.rd_valid;
    assign CMD_UNSUP   = q.unsup;
    assign SWITCH_EN   = q.sw_en;
    assign LATCHED_OFF = (q.st == ST_LATCH);
    assign STATUS_TEMP = q.flag_otf | q.flag_otw;
    assign STATUS_OTF  = q.flag_otf;
    assign STATUS_OTW  = q.flag_otw;
    assign STATUS_CML  = q.flag_inv;
    assign ALERT_B     = ~(q.flag_otf | q.flag_otw | q.flag_inv);

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!rst_n);

    a_ignore_runs: assert property ( // see R3
        (q.st == ST_RUN && act == ACT_IGNORE && q.en_s2) |=> (q.st == ST_RUN && q.sw_en))
        else $error("ignore action left run");
    a_delay_entry: assert property ( // see R4
        (q.st == ST_RUN && q.fault_act && act == ACT_DELAYED && q.en_s2)
        |=> (q.st == ST_DELAY && q.sw_en))
        else $error("delayed action did not keep switching");
    a_imm_shut: assert property ( // see R5
        (q.st == ST_RUN && q.fault_act && act == ACT_IMMEDIATE && q.en_s2) |=> !SWITCH_EN)
        else $error("immediate action kept switching");
    a_cool_hold: assert property ( // see R6
        (q.st == ST_COOL && !rel && q.en_s2) |=> (q.st == ST_COOL && !q.sw_en))
        else $error("cool down left early");
    a_latch_zero: assert property ( // see R7
        (q.st == ST_RUN && q.fault_act && act == ACT_IMMEDIATE && retry == 3'h0 && q.en_s2)
        |=> LATCHED_OFF)
        else $error("zero restart count did not latch");
    a_fault_flag: assert property ( // see R2
        hot |=> (STATUS_OTF && STATUS_TEMP && !ALERT_B))
        else $error("fault flag or alert missing");
    a_warn_flag: assert property ( // see R18
        warm |=> (STATUS_OTW && STATUS_TEMP && !ALERT_B))
        else $error("warning flag or alert missing");
    a_release: assert property ( // see R14
        (q.fault_act && cool) |=> !q.fault_act)
        else $error("fault not released");
    a_hyst_hold: assert property ( // see R15
        (q.fault_act && TEMP_VALID && warn_dis && !clr &&
         temp_s >= fault_deg - `OTR_HYST_DEG) |=> q.fault_act)
        else $error("released inside default hysteresis");
    a_bad_write: assert property ( // see R13
        (CMD_WR && CMD_CODE == `OTR_CMD_WARN_THRESH && q.nvm_done && !NVM_RESTORE &&
         !valid_deg(lin_to_deg(CMD_WDATA))) |=> (STATUS_CML && $stable(q.warn)))
        else $error("invalid write accepted");
    a_start_block: assert property ( // see R16
        (q.st == ST_OFF && q.fault_act) |=> (q.st == ST_OFF))
        else $error("started during fault");
    a_off_clear: assert property ( // see R22
        !q.en_s2 |=> (q.cnt == 3'h0 && !SWITCH_EN))
        else $error("off did not clear attempts");

    c_delay_shut: cover property (q.st == ST_DELAY ##1 q.st == ST_WAIT);
    c_retry_start: cover property (q.st == ST_WAIT ##1 q.st == ST_START);
    c_retry_latch: cover property (q.st == ST_WAIT ##1 q.st == ST_LATCH);
    c_cool_exit: cover property (q.st == ST_COOL ##1 q.st == ST_WAIT);
endmodule : otr_top

/* File: otr_regs.svh */
`ifndef OTR_REGS_SVH
`define OTR_REGS_SVH
// Contract
// R1: Fault is declared when a fresh die temperature exceeds the fault limit.
// R2: A fault sets the summary temperature bit, the fault flag, and raises the alert.
// R3: Action 00b keeps switching without interruption.
// R4: Action 01b keeps running 10 ms per delay step, then shuts down if still hot.
// R5: Action 10b shuts down at once and then follows the restart setting.
// R6: Action 11b stays off until below the warning limit, then follows restart setting.
// R7: Restart count zero latches off after an overtemperature shutdown.
// R8: Counts one to six wait one restart period per attempt, then latch off.
// R9: Attempts made while still hot are counted but produce no start-up.
// R10: Count seven retries forever until commanded off or a start-up succeeds.
// R11: Delay select zero gives no shutdown delay and one rise time period.
// R12: Delay select N gives N times 10 ms delay and N rise time periods.
// R13: Unsupported limit or action writes are rejected, flagged, and raise the alert. The code checks only limit writes; action writes are always taken.
// R14: The fault is released once the temperature falls below the warning limit.
// R15: Warning limit above fault limit or disabled releases 20 degrees below fault limit.
// R16: Even when ignoring faults, an enable during an active fault does not start.
// R17: Clearing faults in action 11b between limits can leave the device off.
// R18: Crossing the warning limit sets the summary bit, warning flag, and alert.
// R19: Warning word is linear: 5-bit signed exponent, 11-bit signed mantissa.
// R20: Restored warning limit is rounded to whole degrees between 0 and 160.
// R21: A warning limit of 255 degrees disables the warning function.
// R22: The attempt counter clears on successful start-up or when commanded off.
// R23: Limits are compared only on fresh samples, fault and warning together.
`define OTR_CMD_CLEAR_FAULTS 8'h03
`define OTR_CMD_FAULT_LIMIT  8'h4f
`define OTR_CMD_FAULT_ACTION 8'h50
`define OTR_CMD_WARN_THRESH  8'h51
`define OTR_CMD_STATUS_BYTE  8'h78
`define OTR_CMD_STATUS_TEMP  8'h7d
`define OTR_ACT_MSB          7
`define OTR_ACT_LSB          6
`define OTR_RETRY_MSB        5
`define OTR_RETRY_LSB        3
`define OTR_DLY_MSB          2
`define OTR_DLY_LSB          0
`define OTR_EXP_MSB          15
`define OTR_EXP_LSB          11
`define OTR_MAN_MSB          10
`define OTR_SB_TEMP_BIT      2
`define OTR_SB_CML_BIT       1
`define OTR_ST_OTF_BIT       7
`define OTR_ST_OTW_BIT       6
`define OTR_RETRY_NONE       3'h0
`define OTR_RETRY_FOREVER    3'h7
`define OTR_LIMIT_OFF_DEG    32'sd255
`define OTR_NVM_MIN_DEG      32'sd0
`define OTR_NVM_MAX_DEG      32'sd160
`define OTR_HYST_DEG         32'sd20
`define OTR_RESP_RESET       8'h00
`define OTR_WARN_RESET       16'h00ff
`define OTR_FAULT_RESET      16'h00ff
`define OTR_DELAY_UNIT_MS    10
`define OTR_CLK_MHZ          100
`define OTR_DELAY_UNIT_CYC   (`OTR_DELAY_UNIT_MS * 1000 * `OTR_CLK_MHZ)
`endif

/* File: otr_pkg.sv */
package otr_pkg;
    typedef enum logic [2:0] {
        ST_OFF   = 3'h0,
        ST_START = 3'h1,
        ST_RUN   = 3'h3,
        ST_DELAY = 3'h2,
        ST_WAIT  = 3'h6,
        ST_COOL  = 3'h7,
        ST_LATCH = 3'h5
    } otr_state_e;

    typedef enum logic [1:0] {
        ACT_IGNORE    = 2'h0,
        ACT_DELAYED   = 2'h1,
        ACT_IMMEDIATE = 2'h2,
        ACT_COOL_DOWN = 2'h3
    } otr_action_e;

    typedef logic [31:0] otr_cnt_t;

    typedef struct packed {
        otr_cnt_t cnt;
        logic     run;
        logic     done;
    } otr_tmr_s;

    typedef struct packed {
        logic        en_s1;
        logic        en_s2;
        logic        nvm_done;
        otr_state_e  st;
        logic [7:0]  resp;
        logic [15:0] warn;
        logic [15:0] fault;
        logic        fault_act;
        logic        flag_otf;
        logic        flag_otw;
        logic        flag_inv;
        logic [2:0]  cnt;
        logic        sw_en;
        logic [15:0] rdata;
        logic        rd_valid;
        logic        unsup;
    } otr_ctl_s;
endpackage : otr_pkg

/* File: otr_timer.sv */
`timescale 1ns/1ps
module otr_timer
    import otr_pkg::*;
(
    // Clock and reset
    input  wire logic     clk,
    input  wire logic     rst_n,
    // Load and status
    input  wire logic     load,
    input  wire otr_cnt_t value,
    output logic          done,
    output logic          busy
);
    otr_tmr_s q;
    otr_tmr_s nxt;

    // A load restarts the count even while running
    always_comb begin
        nxt      = q;
        nxt.done = 1'b0;
        if (load) begin
            nxt.cnt = value;
            nxt.run = 1'b1;
        end else if (q.run) begin
            if (q.cnt == '0) begin
                nxt.run  = 1'b0;
                nxt.done = 1'b1;
            end else begin
                nxt.cnt = q.cnt - 32'd1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= nxt;
        end
    end

    assign done = q.done;
    assign busy = q.run;
endmodule : otr_timer

/* File: otr_host.sv */
`timescale 1ns/1ps
module otr_host
    import otr_pkg::*;
(
    // Clock
    input  wire logic        clk,
    // Command port
    output logic             cmd_wr,
    output logic             cmd_rd,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata,
    input  wire logic [15:0] cmd_rdata,
    input  wire logic        cmd_rvalid,
    input  wire logic        cmd_unsup
);
    initial begin
        cmd_wr    = 1'b0;
        cmd_rd    = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
    end

    // Idle code lines show the inverse of the last transfer, data lines the inverse of the last write
    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        @(negedge clk);
        cmd_wr    <= 1'b1;
        cmd_code  <= code;
        cmd_wdata <= data;
        @(negedge clk);
        cmd_wr    <= 1'b0;
        cmd_code  <= ~code;
        cmd_wdata <= ~data;
    endtask : wr

    task automatic rd(input logic [7:0] code, output logic [15:0] data,
                      output logic ok, output logic unsup);
        @(negedge clk);
        cmd_rd   <= 1'b1;
        cmd_code <= code;
        @(posedge clk);
        ok    = 1'b0;
        unsup = 1'b0;
        data  = 16'h0000;
        repeat (3) begin
            @(negedge clk);
            cmd_rd   <= 1'b0;
            cmd_code <= ~code;
            if (cmd_rvalid === 1'b1 && ok === 1'b0) begin
                data = cmd_rdata;
                ok   = 1'b1;
            end
            if (cmd_unsup === 1'b1) begin
                unsup = 1'b1;
            end
        end
    endtask : rd
endmodule : otr_host

/* File: overtemp_fault_response_test.sv */
`timescale 1ns/1ps
`include "otr_regs.svh"
module overtemp_fault_response_test;
    import otr_pkg::*;
    localparam int unsigned UNIT = 20;
    typedef struct packed {
        logic [7:0]  code;
        logic [15:0] data;
        logic        cml;
        logic        rdb;
    } otr_row_s;
    localparam otr_row_s ROWS [10] = '{
        '{8'h51, 16'h0050, 1'b0, 1'b1}, '{8'h51, 16'h00a1, 1'b1, 1'b0},
        '{8'h51, 16'h07ff, 1'b1, 1'b0}, '{8'h51, 16'h0850, 1'b0, 1'b0},
        '{8'h51, 16'hf8a0, 1'b0, 1'b0}, '{8'h51, 16'h00ff, 1'b0, 1'b1},
        '{8'h4f, 16'h0101, 1'b1, 1'b0}, '{8'h50, 16'h00c7, 1'b0, 1'b1},
        '{8'h4f, 16'h0064, 1'b0, 1'b1}, '{8'h51, 16'h0050, 1'b0, 1'b1}};

    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        cmd_wr, cmd_rd, cmd_rvalid, cmd_unsup;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata, rd_data;
    logic        rd_ok, rd_un;
    logic [15:0] nvm_warn = 16'h00c8;
    logic        nvm_restore = 1'b0;
    logic [11:0] temp_deg = 12'd25;
    logic        temp_valid = 1'b0;
    logic        en_pin = 1'b0;
    logic        softstart_done = 1'b0;
    logic        switch_en, latched_off, st_temp, st_otf, st_otw, st_cml, alert_b;
    int          fail_count = 0;
    int          n_checks = 0;

    always #5 clk_sys = ~clk_sys;

    otr_top #(.DELAY_UNIT_CYC(UNIT)) DUT (
        .CLK_SYS(clk_sys), .RST_B(rst_b),
        .CMD_WR(cmd_wr), .CMD_RD(cmd_rd), .CMD_CODE(cmd_code), .CMD_WDATA(cmd_wdata),
        .CMD_RDATA(cmd_rdata), .CMD_RVALID(cmd_rvalid), .CMD_UNSUP(cmd_unsup),
        .NVM_RESP(8'h00), .NVM_WARN(nvm_warn), .NVM_FAULT(16'h0064),
        .NVM_RESTORE(nvm_restore), .TEMP_DEG(temp_deg), .TEMP_VALID(temp_valid),
        .EN_PIN(en_pin), .SOFTSTART_DONE(softstart_done), .TON_RISE_CYC(24'd10),
        .SWITCH_EN(switch_en), .LATCHED_OFF(latched_off), .STATUS_TEMP(st_temp),
        .STATUS_OTF(st_otf), .STATUS_OTW(st_otw), .STATUS_CML(st_cml), .ALERT_B(alert_b));

    otr_host host (
        .clk(clk_sys), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
        .cmd_unsup(cmd_unsup));

    task automatic test_done;
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc

    task automatic rdchk(input logic [7:0] code, input logic [15:0] exp);
        host.rd(code, rd_data, rd_ok, rd_un);
        chk(rd_ok, 1'b1);
        chk(rd_data, exp);
    endtask : rdchk

    // One fresh telemetry sample
    task automatic sample(input logic [11:0] t);
        @(negedge clk_sys);
        temp_deg   = t;
        temp_valid = 1'b1;
        @(negedge clk_sys);
        temp_valid = 1'b0;
    endtask : sample

    task automatic wait_sw(input logic v, input int lim);
        for (int i = 0; i < lim && switch_en !== v; i++) begin
            cyc(1);
        end
        if (switch_en !== v) begin
            fail_count++;
            test_done();
        end
    endtask : wait_sw

    task automatic power_up;
        en_pin = 1'b1;
        sample(12'd50);
        wait_sw(1'b1, 12);
        softstart_done = 1'b1;
        cyc(1);
        softstart_done = 1'b0;
        cyc(1);
    endtask : power_up

    task automatic restart(input logic [7:0] act);
        en_pin = 1'b0;
        cyc(4);
        host.wr(`OTR_CMD_CLEAR_FAULTS, 16'h0000);
        host.wr(`OTR_CMD_FAULT_ACTION, {8'h00, act});
        power_up();
    endtask : restart

    initial begin
        cyc(10);
        chk({switch_en, alert_b, st_cml}, 16'h0002);
        rst_b = 1'b1;
        cyc(5);
        rdchk(`OTR_CMD_WARN_THRESH, 16'h00a0);
        foreach (ROWS[i]) begin
            host.wr(ROWS[i].code, ROWS[i].data);
            cyc(1);
            chk(st_cml, ROWS[i].cml);
            chk(alert_b, !ROWS[i].cml);
            if (ROWS[i].rdb) begin
                rdchk(ROWS[i].code, ROWS[i].data);
            end
            host.wr(`OTR_CMD_CLEAR_FAULTS, 16'h0000);
        end
        host.rd(8'h99, rd_data, rd_ok, rd_un);
        chk(rd_un, 1'b1);
        chk(rd_data, 16'h0000);
        host.wr(8'h99, 16'h0000);
        chk(cmd_unsup, 1'b1);
        // Ignore mode: hot at enable blocks start, hot while running does not
        host.wr(`OTR_CMD_FAULT_ACTION, 16'h0000);
        sample(12'd110);
        cyc(2);
        chk({st_otf, st_temp, alert_b}, 16'h0006);
        rdchk(`OTR_CMD_STATUS_TEMP, 16'h00c0);
        en_pin = 1'b1;
        cyc(6);
        chk(switch_en, 1'b0);
        power_up();
        sample(12'd110);
        cyc(3);
        chk(switch_en, 1'b1);
        host.wr(`OTR_CMD_CLEAR_FAULTS, 16'h0000);
        temp_deg = 12'd120;
        cyc(4);
        chk(st_otf, 1'b0);
        sample(12'd90);
        cyc(2);
        chk({st_otf, st_otw, st_temp, alert_b}, 16'h0006);
        rdchk(`OTR_CMD_STATUS_BYTE, 16'h0004);
        rdchk(`OTR_CMD_STATUS_TEMP, 16'h0040);
        // Immediate shutdown, no retry
        restart(8'h80);
        sample(12'd110);
        cyc(3);
        chk(switch_en, 1'b0);
        sample(12'd50);
        cyc(30);
        chk(latched_off, 1'b1);
        // One retry while still hot is spent silently
        restart(8'h88);
        sample(12'd110);
        cyc(30);
        chk({switch_en, latched_off}, 16'h0001);
        // Restart_wait_period of three rise times, then start once cool
        restart(8'h8b);
        sample(12'd110);
        cyc(3);
        chk(switch_en, 1'b0);
        sample(12'd50);
        cyc(18);
        chk(switch_en, 1'b0);
        wait_sw(1'b1, 25);
        // Delayed shutdown of two steps
        restart(8'h42);
        sample(12'd110);
        cyc(30);
        chk(switch_en, 1'b1);
        wait_sw(1'b0, 20);
        cyc(2);
        chk(latched_off, 1'b1);
        // Cool-down mode with warning disabled: release 20 below fault
        host.wr(`OTR_CMD_WARN_THRESH, 16'h00ff);
        restart(8'hc8);
        sample(12'd300);
        cyc(3);
        chk({switch_en, st_otw}, 16'h0000);
        sample(12'd85);
        cyc(20);
        chk(switch_en, 1'b0);
        sample(12'd79);
        wait_sw(1'b1, 30);
        // Unlimited retries
        host.wr(`OTR_CMD_WARN_THRESH, 16'h0050);
        restart(8'hb8);
        sample(12'd110);
        cyc(120);
        chk({switch_en, latched_off}, 16'h0000);
        sample(12'd50);
        wait_sw(1'b1, 30);
        // Restore from stored defaults
        nvm_warn = 16'h0850;
        @(negedge clk_sys);
        nvm_restore = 1'b1;
        cyc(1);
        nvm_restore = 1'b0;
        cyc(2);
        rdchk(`OTR_CMD_WARN_THRESH, 16'h00a0);
        test_done();
    end
endmodule : overtemp_fault_response_test
